// file: verilog/pbao_port_override.sv
/*
  pin override logic for ports b, c and d: spi and timer compare on b,
  external memory high address on c, timer/serial/interrupt on d.
  assumes peripherals on clk_i; pin levels arrive asynchronously.
*/
`timescale 1ns/1ns
module pbao_port_override (
  // clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 rst_n_i,
  // port registers
  input  wire logic [7:0]           latch_b_i,
  input  wire logic [7:0]           dir_b_i,
  input  wire logic [7:0]           latch_c_i,
  input  wire logic [7:0]           dir_c_i,
  input  wire logic [7:0]           latch_d_i,
  input  wire logic [7:0]           dir_d_i,
  input  wire logic                 pullup_global_off_i,
  input  wire logic                 compat_mode_i,
  // spi
  input  wire logic                 spi_enable_bit_i,
  input  wire logic                 spi_master_select_i,
  input  wire logic                 spi_slave_out_i,
  input  wire logic                 spi_master_out_i,
  input  wire logic                 spi_sck_out_i,
  // timer compare outputs, index 0..4 = t0, t1a, t1b, t1c, t2
  input  wire logic [4:0]           cmp_out_i,
  input  wire logic [4:0]           cmp_en_i,
  // external memory
  input  wire logic                 ext_mem_enable_i,
  input  wire logic [2:0]           ext_mem_mask_code_i,
  input  wire logic [7:0]           ext_mem_addr_hi_i,
  // serial1
  input  wire logic                 serial1_sync_mode_i,
  input  wire logic                 serial1_sync_clk_out_i,
  input  wire logic                 serial1_tx_enable_i,
  input  wire logic                 serial1_tx_out_i,
  // pins
  input  wire logic [7:0]           pin_b_i,
  input  wire logic [7:0]           pin_c_i,
  input  wire logic [7:0]           pin_d_i,
  // pad drive
  output pbao_pkg::pbao_pad_t       pad_b_o,
  output pbao_pkg::pbao_pad_t       pad_c_o,
  output pbao_pkg::pbao_pad_t       pad_d_o,
  // peripheral input feeds
  output logic                      spi_master_in_o,
  output logic                      spi_slave_in_o,
  output logic                      spi_sck_in_o,
  output logic                      spi_select_n_o,
  output logic                      spi_slave_active_o,
  output logic                      timer2_ext_clock_in_o,
  output logic                      timer1_ext_clock_in_o,
  output logic                      timer1_capture_in_o,
  output logic                      ext_irq_3_in_o,
  output logic                      serial1_sync_clk_in_o
);

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [7:0] sync1_b_q, sync2_b_q;
  logic [7:0] sync1_c_q, sync2_c_q;
  logic [7:0] sync1_d_q, sync2_d_q;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      // idle-high reset keeps the select from reading low after reset
      sync1_b_q <= pbao_pkg::PBAO_ONES8;
      sync2_b_q <= pbao_pkg::PBAO_ONES8;
      sync1_c_q <= pbao_pkg::PBAO_ZERO8;
      sync2_c_q <= pbao_pkg::PBAO_ZERO8;
      sync1_d_q <= pbao_pkg::PBAO_ZERO8;
      sync2_d_q <= pbao_pkg::PBAO_ZERO8;
    end else begin
      sync1_b_q <= pin_b_i;
      sync2_b_q <= sync1_b_q;
      sync1_c_q <= pin_c_i;
      sync2_c_q <= sync1_c_q;
      sync1_d_q <= pin_d_i;
      sync2_d_q <= sync1_d_q;
    end
  end

  // ****************************************
  // override build
  // ****************************************
  logic                spi_master;
  logic                spi_slave;
  logic                s1_sync;
  logic                s1_tx;
  logic                t1c_ok;
  logic [2:0]          mask_eff;
  logic [7:0]          c_rel;
  pbao_pkg::pbao_ovr_t ovr_b, ovr_c, ovr_d;

  always_comb begin
    spi_master = spi_enable_bit_i & spi_master_select_i;
    spi_slave  = spi_enable_bit_i & ~spi_master_select_i;
    s1_sync    = serial1_sync_mode_i & ~compat_mode_i;
    s1_tx      = serial1_tx_enable_i & ~compat_mode_i;
    // no timer1 compare c in legacy mode
    t1c_ok     = cmp_en_i[3] & ~compat_mode_i;
    mask_eff   = compat_mode_i ? '0 : ext_mem_mask_code_i;
    for (int i = 0; i < 8; i++) begin
      c_rel[i] = ext_mem_enable_i & ({1'b0, mask_eff} < pbao_pkg::PBAO_XMM_LIMIT[i]);
    end
  end

  always_comb begin
    ovr_b = pbao_pkg::PBAO_OVR_NONE;
    ovr_b.val_en[4]  = cmp_en_i[0];
    ovr_b.val_val[4] = cmp_out_i[0];
    ovr_b.val_en[5]  = cmp_en_i[1];
    ovr_b.val_val[5] = cmp_out_i[1];
    ovr_b.val_en[6]  = cmp_en_i[2];
    ovr_b.val_val[6] = cmp_out_i[2];
    ovr_b.val_en[7]  = cmp_en_i[4] | t1c_ok;
    ovr_b.val_val[7] = cmp_en_i[4] ? cmp_out_i[4] : cmp_out_i[3];
    ovr_b.dir_en[3:0] = {spi_master, spi_slave, spi_slave, spi_slave};
    ovr_b.pu_en[3:0]  = ovr_b.dir_en[3:0];
    ovr_b.pu_val[3:0] = latch_b_i[3:0] & {4{~pullup_global_off_i}};
    // spi drives bits 3..1, bit 0 value untouched
    ovr_b.val_en[3:1]  = {spi_slave, spi_master, spi_master};
    ovr_b.val_val[3:1] = {spi_slave_out_i, spi_master_out_i, spi_sck_out_i};
  end

  always_comb begin
    ovr_c = pbao_pkg::PBAO_OVR_NONE;
    // address high byte on port c
    ovr_c.pu_en   = c_rel;
    ovr_c.dir_en  = c_rel;
    ovr_c.dir_val = pbao_pkg::PBAO_ONES8;
    ovr_c.val_en  = c_rel;
    ovr_c.val_val = ext_mem_addr_hi_i;
    // legacy mode keeps port c output
    if (compat_mode_i) begin
      ovr_c.dir_en = pbao_pkg::PBAO_ONES8;
      ovr_c.pu_en  = pbao_pkg::PBAO_ONES8;
    end
  end

  always_comb begin
    ovr_d = pbao_pkg::PBAO_OVR_NONE;
    // serial1 clock in sync mode only
    ovr_d.val_en[pbao_pkg::PBAO_D_SCLK]  = s1_sync;
    ovr_d.val_val[pbao_pkg::PBAO_D_SCLK] = serial1_sync_clk_out_i;
    ovr_d.dir_en[pbao_pkg::PBAO_D_SCLK]  = s1_sync;
    ovr_d.dir_val[pbao_pkg::PBAO_D_SCLK] = dir_d_i[pbao_pkg::PBAO_D_SCLK_DIR];
    ovr_d.pu_en[pbao_pkg::PBAO_D_TX]   = s1_tx;
    ovr_d.dir_en[pbao_pkg::PBAO_D_TX]  = s1_tx;
    ovr_d.dir_val[pbao_pkg::PBAO_D_TX] = 1'b1;
    ovr_d.val_en[pbao_pkg::PBAO_D_TX]  = s1_tx;
    ovr_d.val_val[pbao_pkg::PBAO_D_TX] = serial1_tx_out_i;
  end

  // ****************************************
  // pad registers
  // ****************************************
  pbao_pkg::pbao_pad_t pad_b_q, pad_c_q, pad_d_q;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pad_b_q <= pbao_pkg::PBAO_PAD_RST;
      pad_c_q <= pbao_pkg::PBAO_PAD_RST;
      pad_d_q <= pbao_pkg::PBAO_PAD_RST;
    end else begin
      pad_b_q <= pbao_pkg::pbao_apply(ovr_b, latch_b_i, dir_b_i, pullup_global_off_i);
      pad_c_q <= pbao_pkg::pbao_apply(ovr_c, latch_c_i, dir_c_i, pullup_global_off_i);
      pad_d_q <= pbao_pkg::pbao_apply(ovr_d, latch_d_i, dir_d_i, pullup_global_off_i);
    end
  end

  assign pad_b_o = pad_b_q;
  assign pad_c_o = pad_c_q;
  assign pad_d_o = pad_d_q;

  // ****************************************
  // input feeds
  // ****************************************
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      spi_master_in_o    <= 1'b0;
      spi_slave_in_o     <= 1'b0;
      spi_sck_in_o       <= 1'b0;
      spi_select_n_o     <= 1'b1;
      spi_slave_active_o <= 1'b0;
    end else begin
      spi_master_in_o    <= sync2_b_q[pbao_pkg::PBAO_B_MISO];
      spi_slave_in_o     <= sync2_b_q[pbao_pkg::PBAO_B_MOSI];
      spi_sck_in_o       <= sync2_b_q[pbao_pkg::PBAO_B_SCK];
      spi_select_n_o     <= sync2_b_q[pbao_pkg::PBAO_B_SELECT];
      spi_slave_active_o <= spi_slave & ~sync2_b_q[pbao_pkg::PBAO_B_SELECT];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      timer2_ext_clock_in_o <= 1'b0;
      timer1_ext_clock_in_o <= 1'b0;
      timer1_capture_in_o   <= 1'b0;
      ext_irq_3_in_o        <= 1'b0;
      serial1_sync_clk_in_o <= 1'b0;
    end else begin
      timer2_ext_clock_in_o <= sync2_d_q[pbao_pkg::PBAO_D_T2CLK];
      timer1_ext_clock_in_o <= sync2_d_q[pbao_pkg::PBAO_D_T1CLK];
      timer1_capture_in_o   <= sync2_d_q[pbao_pkg::PBAO_D_CAPTURE];
      ext_irq_3_in_o        <= sync2_d_q[pbao_pkg::PBAO_D_TX];
      // clock input only in sync mode
      serial1_sync_clk_in_o <= s1_sync & sync2_d_q[pbao_pkg::PBAO_D_SCLK];
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  logic [1:0] settle_q;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      settle_q <= 2'h0;
    end else if (settle_q != pbao_pkg::PBAO_FEED_LAT) begin
      settle_q <= settle_q + 2'h1;
    end
  end

  property p_slave_select_in;
    @(posedge clk_i) disable iff (!rst_n_i)
      (spi_enable_bit_i && !spi_master_select_i) |=> !pad_b_o.oe[0];
  endproperty
  a_slave_select_in: assert property (p_slave_select_in)
    else $error("select pin not forced input in spi slave mode");

  property p_slave_active;
    @(posedge clk_i) disable iff (!rst_n_i)
      (spi_enable_bit_i && !spi_master_select_i && !pin_b_i[0]) [*3]
        |=> spi_slave_active_o;
  endproperty
  a_slave_active: assert property (p_slave_active)
    else $error("spi slave not active while select held low");

  property p_master_select_dir;
    @(posedge clk_i) disable iff (!rst_n_i)
      (spi_enable_bit_i && spi_master_select_i) |=> pad_b_o.oe[0] == $past(dir_b_i[0]);
  endproperty
  a_master_select_dir: assert property (p_master_select_dir)
    else $error("select direction overridden in spi master mode");

  property p_forced_pullup;
    @(posedge clk_i) disable iff (!rst_n_i)
      (spi_enable_bit_i && !spi_master_select_i)
        |=> pad_b_o.pull[1] == ($past(latch_b_i[1]) && !$past(pullup_global_off_i));
  endproperty
  a_forced_pullup: assert property (p_forced_pullup)
    else $error("forced spi input lost latch pull-up");

  property p_compare_value;
    @(posedge clk_i) disable iff (!rst_n_i)
      cmp_en_i[2] |=> pad_b_o.out[6] == $past(cmp_out_i[2]) && pad_b_o.oe[6] == $past(dir_b_i[6]);
  endproperty
  a_compare_value: assert property (p_compare_value)
    else $error("compare output or direction wrong on pb6");

  property p_bit0_value;
    @(posedge clk_i) disable iff (!rst_n_i)
      1'b1 |=> pad_b_o.out[0] == $past(latch_b_i[0]);
  endproperty
  a_bit0_value: assert property (p_bit0_value)
    else $error("pb0 output value overridden");

  property p_spi_route;
    @(posedge clk_i) disable iff (!rst_n_i)
      (settle_q == pbao_pkg::PBAO_FEED_LAT)
        |-> $past(pin_b_i[3], 3) == spi_master_in_o ##1 $past(pin_b_i[2], 3) == spi_slave_in_o;
  endproperty
  a_spi_route: assert property (p_spi_route)
    else $error("spi input routing wrong");

  property p_legacy_out;
    @(posedge clk_i) disable iff (!rst_n_i)
      compat_mode_i |=> pad_c_o.oe == pbao_pkg::PBAO_ONES8;
  endproperty
  a_legacy_out: assert property (p_legacy_out)
    else $error("port c not all output in legacy mode");

  property p_mask_release;
    @(posedge clk_i) disable iff (!rst_n_i)
      (ext_mem_enable_i && !compat_mode_i && ext_mem_mask_code_i == 3'h3)
        |=> pad_c_o.out[4] == $past(ext_mem_addr_hi_i[4])
            && pad_c_o.out[5] == $past(latch_c_i[5]);
  endproperty
  a_mask_release: assert property (p_mask_release)
    else $error("port c release threshold wrong");

  property p_legacy_mask;
    @(posedge clk_i) disable iff (!rst_n_i)
      (ext_mem_enable_i && compat_mode_i) |=> pad_c_o.out == $past(ext_mem_addr_hi_i);
  endproperty
  a_legacy_mask: assert property (p_legacy_mask)
    else $error("legacy mode did not release full address byte");

  property p_tx_force;
    @(posedge clk_i) disable iff (!rst_n_i)
      (serial1_tx_enable_i && !compat_mode_i)
        |=> pad_d_o.oe[3] && pad_d_o.out[3] == $past(serial1_tx_out_i);
  endproperty
  a_tx_force: assert property (p_tx_force)
    else $error("pd3 not driving transmit data");

  property p_timer_clock;
    @(posedge clk_i) disable iff (!rst_n_i)
      (settle_q == pbao_pkg::PBAO_FEED_LAT) |-> timer2_ext_clock_in_o == $past(pin_d_i[7], 3);
  endproperty
  a_timer_clock: assert property (p_timer_clock)
    else $error("timer2 external clock feed wrong");

endmodule

// file: verilog/pbao_pkg.sv
/*
  constants, carrier types and helper functions of the port b/c/d
  alternate-function override block.
  assumes one system clock and peripherals that drive their override
  requests as plain levels in that clock's domain.
*/
// Function
// - spi slave forces select pin input
// - spi slave active only while select low
// - spi master: select direction from b0_dir_bit
// - forced spi inputs keep latch pull-up
// - pb7..4 value-only timer compare overrides
// - pb3..0 pull/dir overrides from spi mode
// - pb3..1 driven by spi; pb0 never
// - pb3..0 inputs routed to spi
// - legacy mode keeps port c output
// - port c carries address bits 8..15
// - pc7..4 released below mask 1..4
// - pc3..0 released below mask 5,6,7,7
// - legacy mode treats mask code as zero
// - legacy mode: pb7 timer2 compare only
// - legacy mode hides serial1 pins on d
// - serial1 clock direction from d4_dir_bit
// - serial1 clock only in synchronous mode
// - pd7/pd6 feed timer external clocks
// - pd4 feeds timer1 capture input
// - pd3 feeds external interrupt 3
// - serial1 transmitter forces pd3 output
package pbao_pkg;

  // ****************************************
  // field positions and codes
  // ****************************************
  localparam int unsigned PBAO_W          = 8;
  localparam int unsigned PBAO_MASK_W     = 3;
  localparam int unsigned PBAO_B_SELECT   = 0;
  localparam int unsigned PBAO_B_SCK      = 1;
  localparam int unsigned PBAO_B_MOSI     = 2;
  localparam int unsigned PBAO_B_MISO     = 3;
  localparam int unsigned PBAO_B_OC_LO    = 4;
  localparam int unsigned PBAO_D_CAPTURE  = 4;
  localparam int unsigned PBAO_D_TX       = 3;
  localparam int unsigned PBAO_D_SCLK     = 5;
  localparam int unsigned PBAO_D_T1CLK    = 6;
  localparam int unsigned PBAO_D_T2CLK    = 7;
  localparam int unsigned PBAO_D_SCLK_DIR = 4;
  // release limits for pc7..pc0, nibble 7 first
  localparam logic [7:0][3:0] PBAO_XMM_LIMIT = 32'h1234_5677;
  localparam logic [7:0] PBAO_ZERO8 = 8'h00;
  localparam logic [7:0] PBAO_ONES8 = 8'hFF;
  // cycles from a pin edge to its registered feed
  localparam logic [1:0] PBAO_FEED_LAT = 2'h3;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic [7:0] pull;
    logic [7:0] oe;
    logic [7:0] out;
  } pbao_pad_t;

  typedef struct packed {
    logic [7:0] pu_en;
    logic [7:0] pu_val;
    logic [7:0] dir_en;
    logic [7:0] dir_val;
    logic [7:0] val_en;
    logic [7:0] val_val;
  } pbao_ovr_t;

  localparam pbao_pad_t PBAO_PAD_RST = '0;
  localparam pbao_ovr_t PBAO_OVR_NONE = '0;

  // ****************************************
  // functions
  // ****************************************
  // merges overrides into the normal latch/direction path
  function automatic pbao_pad_t pbao_apply(input pbao_ovr_t o,
                                           input logic [7:0] latch,
                                           input logic [7:0] dir,
                                           input logic       pullup_global_off);
    pbao_pad_t p;
    p.pull = (o.pu_en & o.pu_val) | (~o.pu_en & latch & ~dir & {8{~pullup_global_off}});
    p.oe   = (o.dir_en & o.dir_val) | (~o.dir_en & dir);
    p.out  = (o.val_en & o.val_val) | (~o.val_en & latch);
    return p;
  endfunction

endpackage

// file: verif/pbao_board_model.sv
/*
  board-side model of one 8-bit port: resolves each pin from the pad
  drive, an external driver and the pad pull-up.
  assumes pads come from the override block on the same clock.
*/
`timescale 1ns/1ns
module pbao_board_model (
  // clock
  input  wire logic                 clk_i,
  // pad drive and board drive
  input  pbao_pkg::pbao_pad_t       pad_i,
  input  wire logic [7:0]           ben_i,
  input  wire logic [7:0]           bval_i,
  // resolved pins
  output logic [7:0]                pin_o
);
  logic [7:0] float_q = 8'h00;
  logic [7:0] driven;

  // ****************************************
  // pin resolution
  // ****************************************
  assign driven = pad_i.oe | ben_i;

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pad_i.oe[i]) begin
        pin_o[i] = pad_i.out[i];
      end else if (ben_i[i]) begin
        pin_o[i] = bval_i[i];
      end else if (pad_i.pull[i]) begin
        pin_o[i] = 1'b1;
      end else begin
        pin_o[i] = float_q[i];
      end
    end
  end

  // released line shows the inverse of its last level
  always_ff @(posedge clk_i) begin
    for (int i = 0; i < 8; i++) begin
      if (driven[i] || pad_i.pull[i]) begin
        float_q[i] <= ~pin_o[i];
      end
    end
  end
endmodule

// file: verif/testbench.sv
/*
  self-checking bench of the port b/c/d override block with a bench model.
  assumes the board model file and the design package are compiled first.
*/
`timescale 1ns/1ns
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin bad_count++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module testbench;
  logic                clk_i, rst_n_i;
  logic [7:0]          latch_b_i, dir_b_i, latch_c_i, dir_c_i, latch_d_i, dir_d_i;
  logic                pullup_global_off_i, compat_mode_i, spi_enable_bit_i;
  logic                spi_master_select_i, spi_slave_out_i, spi_master_out_i;
  logic                spi_sck_out_i, ext_mem_enable_i, serial1_sync_mode_i;
  logic                serial1_sync_clk_out_i, serial1_tx_enable_i, serial1_tx_out_i;
  logic [4:0]          cmp_out_i, cmp_en_i;
  logic [2:0]          ext_mem_mask_code_i;
  logic [7:0]          ext_mem_addr_hi_i, pin_b_i, pin_c_i, pin_d_i;
  logic [23:0]         ben, bval;
  pbao_pkg::pbao_pad_t pad_b_o, pad_c_o, pad_d_o, eb, ec, ed;
  logic                spi_master_in_o, spi_slave_in_o, spi_sck_in_o, spi_select_n_o;
  logic                spi_slave_active_o, timer2_ext_clock_in_o, timer1_ext_clock_in_o;
  logic                timer1_capture_in_o, ext_irq_3_in_o, serial1_sync_clk_in_o;
  logic [9:0]          feeds, efeed;
  int                  bad_count, cmp_count, cyc;

  pbao_port_override pbao_port_override_inst (
    .clk_i, .rst_n_i, .latch_b_i, .dir_b_i, .latch_c_i, .dir_c_i, .latch_d_i, .dir_d_i,
    .pullup_global_off_i, .compat_mode_i, .spi_enable_bit_i, .spi_master_select_i,
    .spi_slave_out_i, .spi_master_out_i, .spi_sck_out_i, .cmp_out_i, .cmp_en_i,
    .ext_mem_enable_i, .ext_mem_mask_code_i, .ext_mem_addr_hi_i, .serial1_sync_mode_i,
    .serial1_sync_clk_out_i, .serial1_tx_enable_i, .serial1_tx_out_i, .pin_b_i,
    .pin_c_i, .pin_d_i, .pad_b_o, .pad_c_o, .pad_d_o, .spi_master_in_o, .spi_slave_in_o,
    .spi_sck_in_o, .spi_select_n_o, .spi_slave_active_o, .timer2_ext_clock_in_o,
    .timer1_ext_clock_in_o, .timer1_capture_in_o, .ext_irq_3_in_o, .serial1_sync_clk_in_o);
  pbao_board_model board_b (.clk_i(clk_i), .pad_i(pad_b_o), .ben_i(ben[7:0]),
    .bval_i(bval[7:0]), .pin_o(pin_b_i));
  pbao_board_model board_c (.clk_i(clk_i), .pad_i(pad_c_o), .ben_i(ben[15:8]),
    .bval_i(bval[15:8]), .pin_o(pin_c_i));
  pbao_board_model board_d (.clk_i(clk_i), .pad_i(pad_d_o), .ben_i(ben[23:16]),
    .bval_i(bval[23:16]), .pin_o(pin_d_i));

  assign feeds = {spi_master_in_o, spi_slave_in_o, spi_sck_in_o, spi_select_n_o,
    spi_slave_active_o, timer2_ext_clock_in_o, timer1_ext_clock_in_o,
    timer1_capture_in_o, ext_irq_3_in_o, serial1_sync_clk_in_o};

  // ****************************************
  // clock, timeout, verdict
  // ****************************************
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic tally_and_finish();
    if (bad_count == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      tally_and_finish();
    end
  end

  // ****************************************
  // bench model
  // ****************************************
  // override replaces normal path
  function automatic pbao_pkg::pbao_pad_t mrg(logic [7:0] pe, pv, de, dv, ve, vv, la, di,
                                              logic pullup_global_off);
    mrg.pull = (pe & pv) | (~pe & la & ~di & {8{~pullup_global_off}});
    mrg.oe   = (de & dv) | (~de & di);
    mrg.out  = (ve & vv) | (~ve & la);
  endfunction

  function automatic void mdl();
    logic       lg, slv, mst, syn, tx, pullup_global_off;
    logic [7:0] fb, vb, rel, lim [8];
    int         m;
    lg  = compat_mode_i;
    pullup_global_off = pullup_global_off_i;
    slv = spi_enable_bit_i & ~spi_master_select_i;
    mst = spi_enable_bit_i & spi_master_select_i;
    syn = serial1_sync_mode_i & ~lg;
    tx  = serial1_tx_enable_i & ~lg;
    fb = {4'h0, mst, slv, slv, slv};
    vb = {cmp_en_i[4] | (cmp_en_i[3] & ~lg), cmp_en_i[2:0], slv, mst, mst, 1'b0};
    eb = mrg(fb, latch_b_i & {8{~pullup_global_off}}, fb, 8'h00, vb,
      {cmp_en_i[4] ? cmp_out_i[4] : cmp_out_i[3], cmp_out_i[2:0], spi_slave_out_i,
       spi_master_out_i, spi_sck_out_i, 1'b0}, latch_b_i, dir_b_i, pullup_global_off);
    lim = '{7, 7, 6, 5, 4, 3, 2, 1};
    m = lg ? 0 : int'(ext_mem_mask_code_i);
    for (int i = 0; i < 8; i++) begin
      rel[i] = ext_mem_enable_i & (m < int'(lim[i]));
    end
    ec = mrg(rel | {8{lg}}, 8'h00, rel | {8{lg}}, 8'hFF, rel, ext_mem_addr_hi_i,
      latch_c_i, dir_c_i, pullup_global_off);
    ed = mrg({4'h0, tx, 3'h0}, 8'h00, {2'h0, syn, 1'b0, tx, 3'h0},
      {2'h0, dir_d_i[4], 1'b0, 1'b1, 3'h0}, {2'h0, syn, 1'b0, tx, 3'h0},
      {2'h0, serial1_sync_clk_out_i, 1'b0, serial1_tx_out_i, 3'h0},
      latch_d_i, dir_d_i, pullup_global_off);
    efeed = {pin_b_i[3], pin_b_i[2], pin_b_i[1], pin_b_i[0], slv & ~pin_b_i[0],
      pin_d_i[7], pin_d_i[6], pin_d_i[4], pin_d_i[3], pin_d_i[5] & syn};
  endfunction

  task automatic chk_pads();
    mdl();
    `CHK(pad_b_o, eb)
    `CHK(pad_c_o, ec)
    `CHK(pad_d_o, ed)
  endtask

  task automatic chk_reset();
    `CHK({pad_b_o, pad_c_o, pad_d_o}, 72'h0)
    `CHK(feeds, 10'h040)
  endtask

  // ****************************************
  // stimulus
  // ****************************************
  task automatic rnd(int k);
    {latch_b_i, dir_b_i, latch_c_i, dir_c_i} = $urandom();
    {latch_d_i, dir_d_i, ext_mem_addr_hi_i, cmp_out_i, ext_mem_mask_code_i} = $urandom();
    {cmp_en_i, pullup_global_off_i, compat_mode_i, spi_enable_bit_i, spi_master_select_i,
     spi_slave_out_i, spi_master_out_i, spi_sck_out_i, ext_mem_enable_i,
     serial1_sync_mode_i, serial1_sync_clk_out_i, serial1_tx_enable_i,
     serial1_tx_out_i} = 17'($urandom());
    ben  = 24'($urandom());
    bval = 24'($urandom());
    if (k < 32) begin
      {spi_master_select_i, compat_mode_i, ext_mem_mask_code_i} = 5'(k);
      ext_mem_enable_i = 1'b1;
      spi_enable_bit_i = 1'b1;
    end
  endtask

  initial begin
    rst_n_i = 1'b0;
    {latch_b_i, dir_b_i, latch_c_i, dir_c_i, latch_d_i, dir_d_i} = '0;
    {pullup_global_off_i, compat_mode_i, spi_enable_bit_i, spi_master_select_i} = '0;
    {spi_slave_out_i, spi_master_out_i, spi_sck_out_i, ext_mem_enable_i} = '0;
    {serial1_sync_mode_i, serial1_sync_clk_out_i, serial1_tx_enable_i} = '0;
    {serial1_tx_out_i, cmp_out_i, cmp_en_i, ext_mem_mask_code_i} = '0;
    {ext_mem_addr_hi_i, ben, bval} = '0;
    bad_count = 0;
    cmp_count = 0;
    cyc = 0;
    void'($urandom(32'hf259));
    repeat (10) @(posedge clk_i);
    #1;
    chk_reset();
    rst_n_i = 1'b1;
    for (int k = 0; k < 400; k++) begin
      rnd(k);
      @(posedge clk_i);
      #1;
      chk_pads();
      repeat (4) @(posedge clk_i);
      #1;
      chk_pads();
      `CHK(feeds, efeed)
      if (k == 200) begin
        rst_n_i = 1'b0;
        #1;
        chk_reset();
        repeat (2) @(posedge clk_i);
        #1;
        rst_n_i = 1'b1;
      end
    end
    tally_and_finish();
  end
endmodule
